// file: core/rsc_reset_ctrl.v
// reset source combiner with sticky cause flags
`timescale 1ns/1ps
// What this block does
// - five reset causes each reset the device
// - other registers reset; cause flags source dependent
// - hold core while supply below threshold
// - after power-on and oscillator, fetch 0000H
// - power-on sets cold-start flag
// - cold-start flag kept through warm resets
// - brown-out resets only when enable bit set
// - brown-out reset sets brown-out cause flag
// - brown-out flag kept through warm resets
// - software may set or clear brown-out flag
// - pin low 24 cycles is valid request
// - pin reset applied synchronously to clock
// - stay in reset while pin low
// - pin high releases, execution at 0000H
// - power-down pin low wakes clock first
// - pin reset sets pin cause flag
// - pin flag kept through warm resets
// - software clears pin flag by zero
`include "rsc_defs.vh"
module rsc_reset_ctrl #(
  parameter PIN_LOW_CYCLES = `RSC_PIN_LOW_CYCLES,
  parameter OSC_SETTLE_CYC = `RSC_OSC_SETTLE_CYC,
  parameter RST_HOLD_CYC   = `RSC_RST_HOLD_CYC
) (
  input  wire       core_clk,
  input  wire       srst,
  input  wire       por_low,
  input  wire       bod_below,
  input  wire       rst_pin_n,
  input  wire       wdt_timeout,
  input  wire       power_down,
  input  wire [7:0] reg_addr,
  input  wire [7:0] reg_wdata,
  input  wire       reg_wr,
  input  wire       reg_rd,
  output reg  [7:0] reg_rdata,
  output reg        core_rst,
  output reg  [15:0] fetch_addr,
  output reg        clk_wake_req
);
  localparam ST_POR  = 2'd0;
  localparam ST_OSC  = 2'd1;
  localparam ST_HOLD = 2'd2;
  localparam ST_RUN  = 2'd3;
  localparam CW = 6;

  reg [1:0]    state_ff;
  reg [1:0]    nxt_state;
  reg [CW-1:0] cnt_ff;
  reg [CW-1:0] nxt_cnt;
  reg [CW-1:0] pin_cnt_ff;
  reg          pin_meta_ff;
  reg          pin_sync_ff;
  reg          cold_start_flag_ff;
  reg          brownout_cause_flag_ff;
  reg          pin_reset_cause_flag_ff;
  reg          wdt_cause_flag_ff;
  reg          sw_cause_flag_ff;
  reg          brownout_reset_enable_ff;
  reg          sw_req_ff;
  reg          pwr_lo_ff;
  reg          wdt_rst_ff;
  reg          sw_rst_ff;
  reg          bod_rst_ff;
  reg          pin_rst_ff;
  reg [2:0]    cause_ff;

  wire pin_valid = (pin_cnt_ff >= PIN_LOW_CYCLES[CW-1:0]);
  wire bod_trip  = bod_below & brownout_reset_enable_ff;
  wire warm_src  = bod_trip | pin_valid | wdt_timeout | sw_req_ff;
  wire wr_pwr    = reg_wr & (reg_addr == `RSC_OFS_PWR_CTRL);
  wire wr_aux    = reg_wr & (reg_addr == `RSC_OFS_AUX_CTRL1);
  wire wr_bod    = reg_wr & (reg_addr == `RSC_OFS_BOD_CTRL0);
  wire wr_rst    = reg_wr & (reg_addr == `RSC_OFS_RST_CTRL);
  wire enter_rst = (state_ff == ST_RUN) & warm_src;

  // reset path sees pin only through two flops
  always @(posedge core_clk)
  begin
    if (srst)
    begin
      pin_meta_ff <= 1'b1;
      pin_sync_ff <= 1'b1;
      pin_cnt_ff  <= {CW{1'b0}};
    end
    else
    begin
      pin_meta_ff <= rst_pin_n;
      pin_sync_ff <= pin_meta_ff;
      if (pin_sync_ff)
        pin_cnt_ff <= {CW{1'b0}};
      else if (!pin_valid)
        pin_cnt_ff <= pin_cnt_ff + 1'b1;
    end
  end

  // wake request is raised from the raw pin; clock logic outside acts on it
  always @(posedge core_clk)
  begin
    if (srst)
      clk_wake_req <= 1'b0;
    else
      clk_wake_req <= power_down & ~rst_pin_n;
  end

  always @*
  begin
    nxt_state = state_ff;
    nxt_cnt   = cnt_ff;
    case (state_ff)
      ST_POR:
      begin
        nxt_cnt = {CW{1'b0}};
        if (!por_low)
          nxt_state = ST_OSC;
      end
      ST_OSC:
      begin
        if (cnt_ff >= OSC_SETTLE_CYC[CW-1:0] - 1'b1)
        begin
          nxt_state = ST_HOLD;
          nxt_cnt   = {CW{1'b0}};
        end
        else
          nxt_cnt = cnt_ff + 1'b1;
      end
      ST_HOLD:
      begin
        if (warm_src | ~pin_sync_ff)
          nxt_cnt = {CW{1'b0}};
        else if (cnt_ff >= RST_HOLD_CYC[CW-1:0] - 1'b1)
          nxt_state = ST_RUN;
        else
          nxt_cnt = cnt_ff + 1'b1;
      end
      ST_RUN:
      begin
        nxt_cnt = {CW{1'b0}};
        if (warm_src)
          nxt_state = ST_HOLD;
      end
      default:
        nxt_state = ST_POR;
    endcase
    if (por_low)
      nxt_state = ST_POR;
  end

  always @(posedge core_clk)
  begin
    if (srst)
    begin
      state_ff   <= ST_POR;
      cnt_ff     <= {CW{1'b0}};
      core_rst   <= 1'b1;
      fetch_addr <= `RSC_RESET_VECTOR;
    end
    else
    begin
      state_ff   <= nxt_state;
      cnt_ff     <= nxt_cnt;
      core_rst   <= (nxt_state != ST_RUN);
      fetch_addr <= `RSC_RESET_VECTOR;
    end
  end

  // cause latch: which warm source started this reset
  always @(posedge core_clk)
  begin
    if (srst)
    begin
      pwr_lo_ff  <= 1'b1;
      bod_rst_ff <= 1'b0;
      pin_rst_ff <= 1'b0;
      wdt_rst_ff <= 1'b0;
      sw_rst_ff  <= 1'b0;
      cause_ff   <= 3'h0;
    end
    else
    begin
      pwr_lo_ff  <= por_low;
      bod_rst_ff <= enter_rst & bod_trip;
      pin_rst_ff <= enter_rst & pin_valid;
      wdt_rst_ff <= enter_rst & wdt_timeout;
      sw_rst_ff  <= enter_rst & sw_req_ff;
      cause_ff   <= {enter_rst, 2'b00};
    end
  end

  // flags: hardware set wins over a software write in the same cycle
  always @(posedge core_clk)
  begin
    if (srst)
    begin
      cold_start_flag_ff       <= 1'b0;
      brownout_cause_flag_ff   <= 1'b0;
      pin_reset_cause_flag_ff  <= 1'b0;
      wdt_cause_flag_ff        <= 1'b0;
      sw_cause_flag_ff         <= 1'b0;
      brownout_reset_enable_ff <= 1'b0;
      sw_req_ff                <= 1'b0;
    end
    else if (pwr_lo_ff)
    begin
      cold_start_flag_ff       <= 1'b1;
      brownout_cause_flag_ff   <= 1'b0;
      pin_reset_cause_flag_ff  <= 1'b0;
      wdt_cause_flag_ff        <= 1'b0;
      sw_cause_flag_ff         <= 1'b0;
      brownout_reset_enable_ff <= 1'b0;
      sw_req_ff                <= 1'b0;
    end
    else
    begin
      if (wr_pwr)
        cold_start_flag_ff <= reg_wdata[`RSC_BIT_COLD_START];
      if (bod_rst_ff)
        brownout_cause_flag_ff <= 1'b1;
      else if (wr_bod)
        brownout_cause_flag_ff <= reg_wdata[`RSC_BIT_BOD_CAUSE];
      if (pin_rst_ff)
        pin_reset_cause_flag_ff <= 1'b1;
      else if (wr_aux & ~reg_wdata[`RSC_BIT_PIN_CAUSE])
        pin_reset_cause_flag_ff <= 1'b0;
      if (wdt_rst_ff)
        wdt_cause_flag_ff <= 1'b1;
      else if (wr_rst & ~reg_wdata[`RSC_BIT_WDT_CAUSE])
        wdt_cause_flag_ff <= 1'b0;
      if (sw_rst_ff)
        sw_cause_flag_ff <= 1'b1;
      else if (wr_aux & ~reg_wdata[`RSC_BIT_SW_CAUSE])
        sw_cause_flag_ff <= 1'b0;
      // enable and request return to defaults on any reset
      if (cause_ff[2])
      begin
        brownout_reset_enable_ff <= 1'b0;
        sw_req_ff                <= 1'b0;
      end
      else
      begin
        if (wr_bod)
          brownout_reset_enable_ff <= reg_wdata[`RSC_BIT_BOD_RST_EN];
        sw_req_ff <= wr_rst & reg_wdata[`RSC_BIT_SW_REQ];
      end
    end
  end

  always @(posedge core_clk)
  begin
    if (srst)
      reg_rdata <= 8'h00;
    else if (reg_rd)
    begin
      case (reg_addr)
        `RSC_OFS_PWR_CTRL:  reg_rdata <= {3'h0, cold_start_flag_ff, 4'h0};
        `RSC_OFS_AUX_CTRL1: reg_rdata <= {sw_cause_flag_ff, pin_reset_cause_flag_ff, 6'h00};
        `RSC_OFS_BOD_CTRL0: reg_rdata <= {5'h00, brownout_reset_enable_ff, brownout_cause_flag_ff, bod_below};
        `RSC_OFS_RST_CTRL:  reg_rdata <= {4'h0, wdt_cause_flag_ff, 3'h0};
        default:            reg_rdata <= 8'h00;
      endcase
    end
    else
      reg_rdata <= 8'h00;
  end
endmodule // rsc_reset_ctrl

// file: core/rsc_defs.vh
// register map, field positions and timing constants for reset source control
`ifndef RSC_DEFS_VH
`define RSC_DEFS_VH
`define RSC_ADDR_W          8
`define RSC_OFS_PWR_CTRL    8'h87
`define RSC_OFS_AUX_CTRL1   8'hA2
`define RSC_OFS_BOD_CTRL0   8'hA3
`define RSC_OFS_RST_CTRL    8'hA4
`define RSC_BIT_COLD_START  4
`define RSC_BIT_PIN_CAUSE   6
`define RSC_BIT_BOD_RST_EN  2
`define RSC_BIT_BOD_CAUSE   1
`define RSC_BIT_BOD_STATUS  0
`define RSC_BIT_WDT_CAUSE   3
`define RSC_BIT_SW_CAUSE    7
`define RSC_BIT_SW_REQ      0
`define RSC_PIN_LOW_CYCLES  24
`define RSC_OSC_SETTLE_CYC  16
`define RSC_RST_HOLD_CYC    4
`define RSC_RESET_VECTOR    16'h0000
`endif

// file: tb/rsc_pin_src.sv
// reset pin source model
`timescale 1ns/1ps
module rsc_pin_src (
  input  wire       core_clk,
  input  wire       pulse_go,
  input  wire [7:0] pulse_len,
  output reg        rst_pin_n
);
  reg [7:0] left_ff = 8'h00;
  initial rst_pin_n = 1'b1;
  // pin rests high on its pull-up once released
  always @(posedge core_clk)
  begin
    left_ff <= pulse_go ? pulse_len : left_ff - {7'h00, left_ff != 8'h00};
    rst_pin_n <= !(pulse_go || left_ff > 8'h01);
  end
endmodule // rsc_pin_src

// file: tb/rsc_reset_ctrl_sva.sv
// port checker for reset source control
`timescale 1ns/1ps
module rsc_reset_ctrl_sva (
  input wire        core_clk,
  input wire        srst,
  input wire        por_low,
  input wire        rst_pin_n,
  input wire        wdt_timeout,
  input wire        power_down,
  input wire        core_rst,
  input wire [15:0] fetch_addr,
  input wire        clk_wake_req
);
  reg [5:0] low_ff;
  // saturates so a stuck pin cannot wrap back to zero
  always @(posedge core_clk)
    low_ff <= (srst || rst_pin_n) ? 6'h00 : low_ff + {5'h00, low_ff != 6'h3F};
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (srst);
  a_vector_zero: assert property (fetch_addr == 16'h0000) else $error("bad vector");
  a_por_hold: assert property (por_low |=> core_rst) else $error("run in por");
  a_osc_wait: assert property ($fell(por_low) |-> core_rst ##1 core_rst ##1 core_rst) else $error("early run");
  a_pin_hold: assert property (core_rst && !rst_pin_n && !$past(rst_pin_n) && !$past(rst_pin_n, 2) |=> core_rst)
    else $error("left reset, pin low");
  a_long_low: assert property (low_ff >= 6'd28 |-> core_rst) else $error("pin low ignored");
  a_pin_release: assert property ($fell(core_rst) |-> $past(rst_pin_n, 3) && !$past(por_low, 3))
    else $error("early release");
  a_wdt_reset: assert property (wdt_timeout |=> core_rst) else $error("wdt ignored");
  a_wake_req: assert property (power_down && !rst_pin_n |=> clk_wake_req) else $error("no wake");
endmodule // rsc_reset_ctrl_sva
bind rsc_reset_ctrl rsc_reset_ctrl_sva i_rsc_reset_ctrl_sva (.core_clk(core_clk), .srst(srst), .por_low(por_low),
  .rst_pin_n(rst_pin_n), .wdt_timeout(wdt_timeout), .power_down(power_down), .core_rst(core_rst),
  .fetch_addr(fetch_addr), .clk_wake_req(clk_wake_req));

// file: tb/test_rsc_reset_ctrl.sv
// self-checking bench for reset source control
`timescale 1ns/1ps
module test_rsc_reset_ctrl;
  reg         core_clk = 1'b0, srst = 1'b1, por_low = 1'b1, bod_below = 1'b0, wdt_timeout = 1'b0;
  reg         power_down = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0, pulse_go = 1'b0;
  reg  [7:0]  reg_addr = 8'h00, reg_wdata = 8'h00, pulse_len = 8'h00;
  wire [7:0]  reg_rdata;
  wire [15:0] fetch_addr;
  wire        core_rst, clk_wake_req, rst_pin_n;
  integer     fail_count = 0, n_checks = 0, cyc = 0, tick = 0;
  rsc_reset_ctrl #(.OSC_SETTLE_CYC(2), .RST_HOLD_CYC(1)) i_rsc_reset_ctrl (.core_clk(core_clk), .srst(srst),
    .por_low(por_low), .bod_below(bod_below), .rst_pin_n(rst_pin_n), .wdt_timeout(wdt_timeout),
    .power_down(power_down), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .core_rst(core_rst), .fetch_addr(fetch_addr), .clk_wake_req(clk_wake_req));
  rsc_pin_src i_rsc_pin_src (.core_clk(core_clk), .pulse_go(pulse_go), .pulse_len(pulse_len), .rst_pin_n(rst_pin_n));
  initial
    forever #5 core_clk = ~core_clk;
  task chk(input [63:0] name, input [7:0] seen, input [7:0] exp);
    if (seen !== exp)
    begin
      fail_count = fail_count + 1;
      $display("[ERR] %0s expected %h seen %h", name, exp, seen);
    end
    else
      n_checks = n_checks + 1;
  endtask
  task wr(input [7:0] a, input [7:0] d);
  begin
    @(posedge core_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge core_clk);
    reg_wr <= 1'b0;
  end
  endtask
  task rd(input [7:0] a, input [7:0] e);
  begin
    @(posedge core_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1 chk("rdata", reg_rdata, e);
  end
  endtask
  task cycles(input integer n);
    repeat (n) @(posedge core_clk);
  endtask
  task pin(input [7:0] n);
  begin
    @(posedge core_clk);
    pulse_len <= n;
    pulse_go <= 1'b1;
    @(posedge core_clk);
    pulse_go <= 1'b0;
  end
  endtask
  // bounded wait for the core to run again
  task run_wait;
  begin
    cyc = 0;
    while (core_rst !== 1'b0 && cyc < 300)
    begin
      @(posedge core_clk);
      cyc = cyc + 1;
    end
    #1 chk("run", {7'h00, core_rst}, 8'h00);
  end
  endtask
  task tally_and_finish;
  begin
    $display("checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  end
  endtask
  always @(posedge core_clk)
  begin
    tick = tick + 1;
    if (tick == 4000)
    begin
      fail_count = fail_count + 1;
      tally_and_finish;
    end
  end
  initial
  begin
    cycles(6);
    srst <= 1'b0;
    cycles(3);
    por_low <= 1'b0;
    run_wait;
    rd(8'h87, 8'h10);
    rd(8'hA2, 8'h00);
    rd(8'hA3, 8'h00);
    rd(8'h55, 8'h00);
    wr(8'h87, 8'h00);
    rd(8'h87, 8'h00);
    wr(8'hA3, 8'h02);
    rd(8'hA3, 8'h02);
    wr(8'hA3, 8'h00);
    bod_below <= 1'b1;
    rd(8'hA3, 8'h01);
    chk("bodoff", {7'h00, core_rst}, 8'h00);
    wr(8'hA3, 8'h04);
    cycles(3);
    chk("bodon", {7'h00, core_rst}, 8'h01);
    bod_below <= 1'b0;
    run_wait;
    rd(8'hA3, 8'h02);
    rd(8'h87, 8'h00);
    pin(8'd20);
    cycles(30);
    chk("short", {7'h00, core_rst}, 8'h00);
    pin(8'd60);
    cycles(40);
    chk("pinrst", {7'h00, core_rst}, 8'h01);
    run_wait;
    rd(8'hA2, 8'h40);
    rd(8'hA3, 8'h02);
    wr(8'hA2, 8'h00);
    rd(8'hA2, 8'h00);
    wdt_timeout <= 1'b1;
    cycles(1);
    wdt_timeout <= 1'b0;
    #1 chk("wdt", {7'h00, core_rst}, 8'h01);
    run_wait;
    rd(8'hA2, 8'h00);
    wr(8'hA4, 8'h01);
    cycles(1);
    #1 chk("sw", {7'h00, core_rst}, 8'h01);
    run_wait;
    rd(8'hA2, 8'h80);
    rd(8'hA3, 8'h02);
    power_down <= 1'b1;
    pin(8'd4);
    cycles(1);
    #1 chk("wake", {7'h00, clk_wake_req}, 8'h01);
    power_down <= 1'b0;
    cycles(8);
    por_low <= 1'b1;
    cycles(3);
    por_low <= 1'b0;
    run_wait;
    rd(8'hA3, 8'h00);
    rd(8'hA2, 8'h00);
    rd(8'h87, 8'h10);
    tally_and_finish;
  end
endmodule // test_rsc_reset_ctrl
